// ==== include/video_format_pkg.sv ====
// shared constants, types and decode functions for the format report block
package video_format_pkg;

  // ----------------
  // widths
  // ----------------
  localparam int LANES      = 4;
  localparam int CODE_W     = 4;
  localparam int LINE_W     = 11;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int CLASS_W    = 3;
  localparam int STAT_W     = 4;

  // ----------------
  // register map (byte addresses)
  // ----------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_FORMAT = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_LINES  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS  = 8'h14;

  // field positions
  localparam int CTRL_EXTRACT_BIT = 0;
  localparam int ST_CKS_BIT       = 0;
  localparam int ST_F0_BIT        = 1;
  localparam int ST_F1_BIT        = 2;
  localparam int ST_FMT_BIT       = 3;
  localparam int LINES_F1_LSB     = 16;
  localparam int FLAG_FRAC_BIT    = 0;
  localparam int FLAG_CKS_BIT     = 1;

  // reset values
  localparam logic             CTRL_RESET = 1'h0;
  localparam logic [STAT_W-1:0] MASK_RESET = 4'h0;
  localparam logic [LINE_W-1:0] LINE_RESET = 11'h000;

  // ----------------
  // format codes
  // ----------------
  localparam logic [CODE_W-1:0] FMT_SD486     = 4'h0;
  localparam logic [CODE_W-1:0] FMT_SD576     = 4'h1;
  localparam logic [CODE_W-1:0] FMT_1080I_30  = 4'h4;
  localparam logic [CODE_W-1:0] FMT_1080I_25  = 4'h5;
  localparam logic [CODE_W-1:0] FMT_1080P_24  = 4'h6;
  localparam logic [CODE_W-1:0] FMT_720P_60   = 4'h7;
  localparam logic [CODE_W-1:0] FMT_720P_50   = 4'h8;
  localparam logic [CODE_W-1:0] FMT_720P_30   = 4'h9;
  localparam logic [CODE_W-1:0] FMT_720P_25   = 4'ha;
  localparam logic [CODE_W-1:0] FMT_720P_24   = 4'hb;
  localparam logic [CODE_W-1:0] FMT_1080P_30  = 4'hc;
  localparam logic [CODE_W-1:0] FMT_1080P_25  = 4'hd;
  localparam logic [CODE_W-1:0] FMT_1080I_24  = 4'he;
  localparam logic [CODE_W-1:0] FMT_UNKNOWN   = 4'hf;

  // ----------------
  // types
  // ----------------
  typedef enum logic [CLASS_W-1:0] {
    lines_none, lines_486, lines_576, lines_720, lines_1080
  } lines_class_t;

  typedef enum logic [CLASS_W-1:0] {
    rate_none, rate_24, rate_25, rate_30, rate_50, rate_60
  } rate_class_t;

  typedef enum logic [2:0] {
    mode_sd, mode_hd, mode_3ga, mode_3gb, mode_hd_dual, mode_6g, mode_12g
  } rx_mode_t;

  typedef enum logic [2:0] {
    cfg_single, cfg_dual, cfg_3g, cfg_hd_dual, cfg_triple, cfg_multi
  } core_cfg_t;

  // ----------------
  // decode functions
  // ----------------
  // transport is interlaced when 1080p50 or 1080p60 rides over level b or dual link
  function automatic logic [CODE_W-1:0] encode_format(
    input lines_class_t lines,
    input logic         prog,
    input rate_class_t  rate,
    input logic         split_transport
  );
    logic p;
    p = prog & ~(split_transport & (rate == rate_50 || rate == rate_60));
    encode_format = FMT_UNKNOWN;
    case (lines)
      lines_486:  if (!prog) encode_format = FMT_SD486;
      lines_576:  if (!prog) encode_format = FMT_SD576;
      lines_720:
        if (prog)
        begin
          case (rate)
            rate_60: encode_format = FMT_720P_60;
            rate_50: encode_format = FMT_720P_50;
            rate_30: encode_format = FMT_720P_30;
            rate_25: encode_format = FMT_720P_25;
            rate_24: encode_format = FMT_720P_24;
            default: encode_format = FMT_UNKNOWN;
          endcase
        end
      lines_1080:
        case (rate)
          rate_24:          encode_format = p ? FMT_1080P_24 : FMT_1080I_24;
          rate_25, rate_50: encode_format = p ? FMT_1080P_25 : FMT_1080I_25;
          rate_30, rate_60: encode_format = p ? FMT_1080P_30 : FMT_1080I_30;
          default:          encode_format = FMT_UNKNOWN;
        endcase
      default: encode_format = FMT_UNKNOWN;
    endcase
  endfunction

  function automatic logic lane_valid(input rx_mode_t mode, input int lane);
    case (mode)
      mode_12g: lane_valid = 1'b1;
      mode_6g:  lane_valid = (lane < 2);
      default:  lane_valid = (lane == 0);
    endcase
  endfunction

  function automatic logic link_b_capable(input core_cfg_t cfg);
    link_b_capable = (cfg == cfg_3g) || (cfg == cfg_hd_dual) ||
                     (cfg == cfg_triple) || (cfg == cfg_multi);
  endfunction

endpackage

// ==== include/payload_line_if.sv ====
// carrier between the top and one payload identifier line tracker
interface payload_line_if;
  import video_format_pkg::*;
  logic              found;
  logic [LINE_W-1:0] line;
  logic              updated;
  logic [LINE_W-1:0] line_out;

  modport source  (output found, output line,
                   input updated, input line_out);
  modport tracker (input found, input line,
                   output updated, output line_out);
endinterface

// ==== src/format_lane.sv ====
// one lane's registered format code with change pulse
module format_lane
  import video_format_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // measured lane properties
  input  wire logic              lane_valid_i,
  input  wire logic              lock_i,
  input  wire lines_class_t      lines_i,
  input  wire logic              prog_i,
  input  wire rate_class_t       rate_i,
  input  wire logic              split_i,
  // report
  output logic [CODE_W-1:0]      code_o,
  output logic                   change_o
);

  logic [CODE_W-1:0] nxt_code;

  always_comb
  begin
    nxt_code = FMT_UNKNOWN;
    if (lane_valid_i && lock_i)
    begin
      nxt_code = encode_format(lines_i, prog_i, rate_i, split_i);
    end
  end

  // unknown until a lock, and on losing it
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      code_o   <= FMT_UNKNOWN;
      change_o <= 1'b0;
    end
    else
    begin
      code_o   <= nxt_code;
      change_o <= (nxt_code != code_o);
    end
  end

endmodule

// ==== src/line_tracker.sv ====
// publishes a payload identifier line once two whole frames agree on it
module line_tracker
  import video_format_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // framing
  input  wire logic       enable_i,
  input  wire logic       frame_start_i,
  // tracked field
  payload_line_if.tracker lt
);

  logic              seen_ff;
  logic              prev_ok_ff;
  logic [LINE_W-1:0] cand_ff;
  logic [LINE_W-1:0] prev_ff;
  logic              agree;

  assign agree = seen_ff & prev_ok_ff & (cand_ff == prev_ff);

  // candidate of the running frame and of the last complete one
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !enable_i)
    begin
      seen_ff    <= 1'b0;
      prev_ok_ff <= 1'b0;
      cand_ff    <= LINE_RESET;
      prev_ff    <= LINE_RESET;
    end
    else
    begin
      if (frame_start_i)
      begin
        prev_ok_ff <= seen_ff;
        prev_ff    <= cand_ff;
      end
      // a find beside the frame start belongs to the new frame
      if (lt.found)
      begin
        seen_ff <= 1'b1;
        cand_ff <= lt.line;
      end
      else if (frame_start_i)
      begin
        seen_ff <= 1'b0;
      end
    end
  end

  // output moves only on agreement of two complete frames
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      lt.line_out <= LINE_RESET;
      lt.updated  <= 1'b0;
    end
    else
    begin
      lt.updated <= 1'b0;
      if (enable_i && frame_start_i && agree && cand_ff != lt.line_out)
      begin
        lt.line_out <= cand_ff;
        lt.updated  <= 1'b1;
      end
    end
  end

endmodule

// ==== src/rx_video_format_report.sv ====
// receive side format code, payload identifier line and checksum report
//
// Behaviour
// R01: with extraction on and link b present, flag link b identifier checksum errors
// R02: publish field 0 identifier line after two complete frames
// R03: publish field 1 identifier line after two complete frames
// R04: code reports transport format, so 1080p50 on dual link reads 1080i50
// R05: four-bit codes for sd, 1080i, 1080p and 720p formats as tabled
// R06: code 1111 when nothing detected; reserved codes never produced
// R07: code 0100 also covers 1080p60 and 59.94 over level b or dual link
// R08: code 0101 also covers 1080p50 over level b or dual link
// R09: provide fractional rate flag; receiver combines it with the code
// R10: receiver uses the standard indicator to resolve code 1100
// R11: receiver should prefer payload identifier for exact format details
// R12: six and twelve gig modes give each 20-bit lane its own code
// R13: twelve gig fills all four lanes, six gig only the lower two
// R14: codes unknown and lines held at reset values until detection
//
// The implementer's own choices: the address map and the plain strobed port.
module rx_video_format_report
  import video_format_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_i,
  // register port
  input  wire logic [ADDR_W-1:0]        reg_addr_i,
  input  wire logic [DATA_W-1:0]        reg_wdata_i,
  input  wire logic                     reg_wr_i,
  input  wire logic                     reg_rd_i,
  output logic      [DATA_W-1:0]        reg_rdata_o,
  // interrupt
  output logic                          irq_o,
  // receiver configuration and mode
  input  wire core_cfg_t                core_cfg_i,
  input  wire rx_mode_t                 mode_i,
  input  wire logic                     fractional_i,
  // per lane measurements
  input  wire logic [LANES-1:0]         lane_lock_i,
  input  wire logic [LANES-1:0]         lane_prog_i,
  input  wire logic [LANES*CLASS_W-1:0] lane_lines_i,
  input  wire logic [LANES*CLASS_W-1:0] lane_rate_i,
  // payload identifier events
  input  wire logic                     frame_start_i,
  input  wire logic                     pid_found_i,
  input  wire logic                     pid_field_i,
  input  wire logic [LINE_W-1:0]        pid_line_i,
  input  wire logic                     pid_b_valid_i,
  input  wire logic                     pid_b_cks_err_i,
  // report
  output logic [LANES*CODE_W-1:0]       format_code_o,
  output logic                          fractional_rate_flag_o,
  output logic [LINE_W-1:0]             payload_id_line_field_zero_o,
  output logic [LINE_W-1:0]             payload_id_line_field_one_o,
  output logic                          pid_b_cks_error_o
);

  // ----------------
  // declarations
  // ----------------
  logic                   extract_en_ff;
  logic [STAT_W-1:0]      status_ff;
  logic [STAT_W-1:0]      mask_ff;
  logic [STAT_W-1:0]      events;
  logic [STAT_W-1:0]      w1c;
  logic [LANES-1:0]       lane_change;
  logic                   split_transport;
  logic                   cks_watch;
  logic                   cks_event;
  logic                   wr_ctrl;
  logic                   wr_status;
  logic                   wr_mask;
  logic [DATA_W-1:0]      nxt_rdata;

  payload_line_if f0_if ();
  payload_line_if f1_if ();

  // ----------------
  // format code per lane
  // ----------------
  // level b and dual link carry progressive 50/60 as interlaced pairs
  assign split_transport = (mode_i == mode_3gb) ||
                           (mode_i == mode_hd_dual); // R04 R07 R08

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : gen_lane
      format_lane u_lane (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .lane_valid_i (lane_valid(mode_i, g)), // R12 R13
        .lock_i       (lane_lock_i[g]),
        .lines_i      (lines_class_t'(lane_lines_i[g*CLASS_W +: CLASS_W])),
        .prog_i       (lane_prog_i[g]),
        .rate_i       (rate_class_t'(lane_rate_i[g*CLASS_W +: CLASS_W])),
        .split_i      (split_transport),
        .code_o       (format_code_o[g*CODE_W +: CODE_W]), // R05 R06 R14
        .change_o     (lane_change[g])
      );
    end
  endgenerate

  // ----------------
  // fractional rate flag
  // ----------------
  // registered only; resolving the exact rate is left to the receiver
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      fractional_rate_flag_o <= 1'b0;
    end
    else
    begin
      fractional_rate_flag_o <= fractional_i; // R09
    end
  end

  // ----------------
  // payload identifier line trackers
  // ----------------
  assign f0_if.found = pid_found_i & ~pid_field_i;
  assign f0_if.line  = pid_line_i;
  assign f1_if.found = pid_found_i & pid_field_i;
  assign f1_if.line  = pid_line_i;

  line_tracker u_f0 (
    .clk_i         (clk_i),
    .reset_i       (reset_i),
    .enable_i      (extract_en_ff),
    .frame_start_i (frame_start_i),
    .lt            (f0_if.tracker) // R02
  );

  line_tracker u_f1 (
    .clk_i         (clk_i),
    .reset_i       (reset_i),
    .enable_i      (extract_en_ff),
    .frame_start_i (frame_start_i),
    .lt            (f1_if.tracker) // R03
  );

  // held from the tracker flops; reset value until the first agreement
  assign payload_id_line_field_zero_o = f0_if.line_out; // R02 R14
  assign payload_id_line_field_one_o  = f1_if.line_out; // R03 R14

  // ----------------
  // link b checksum flag
  // ----------------
  // flag follows the outcome of the latest link b identifier
  assign cks_watch = extract_en_ff & link_b_capable(core_cfg_i); // R01
  assign cks_event = cks_watch & pid_b_valid_i & pid_b_cks_err_i; // R01

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pid_b_cks_error_o <= 1'b0;
    end
    else if (!cks_watch)
    begin
      pid_b_cks_error_o <= 1'b0;
    end
    else if (pid_b_valid_i)
    begin
      pid_b_cks_error_o <= pid_b_cks_err_i; // R01
    end
  end

  // ----------------
  // register writes
  // ----------------
  assign wr_ctrl   = reg_wr_i && (reg_addr_i == ADDR_CTRL);
  assign wr_status = reg_wr_i && (reg_addr_i == ADDR_STATUS);
  assign wr_mask   = reg_wr_i && (reg_addr_i == ADDR_MASK);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      extract_en_ff <= CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      extract_en_ff <= reg_wdata_i[CTRL_EXTRACT_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mask_ff <= MASK_RESET;
    end
    else if (wr_mask)
    begin
      mask_ff <= reg_wdata_i[STAT_W-1:0];
    end
  end

  // ----------------
  // interrupt status
  // ----------------
  always_comb
  begin
    events              = '0;
    events[ST_CKS_BIT]  = cks_event;
    events[ST_F0_BIT]   = f0_if.updated;
    events[ST_F1_BIT]   = f1_if.updated;
    events[ST_FMT_BIT]  = |lane_change;
  end

  assign w1c = wr_status ? reg_wdata_i[STAT_W-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      status_ff <= '0;
    end
    else
    begin
      status_ff <= (status_ff & ~w1c) | events;
    end
  end

  // one cycle behind the status so the pin stays a plain flop
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(status_ff & mask_ff);
    end
  end

  // ----------------
  // register reads
  // ----------------
  always_comb
  begin
    nxt_rdata = '0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        ADDR_CTRL:
          nxt_rdata[CTRL_EXTRACT_BIT] = extract_en_ff;
        ADDR_STATUS:
          nxt_rdata[STAT_W-1:0] = status_ff;
        ADDR_MASK:
          nxt_rdata[STAT_W-1:0] = mask_ff;
        ADDR_FORMAT:
          nxt_rdata[LANES*CODE_W-1:0] = format_code_o;
        ADDR_LINES:
        begin
          nxt_rdata[LINE_W-1:0] = f0_if.line_out;
          nxt_rdata[LINES_F1_LSB +: LINE_W] = f1_if.line_out;
        end
        ADDR_FLAGS:
        begin
          nxt_rdata[FLAG_FRAC_BIT] = fractional_rate_flag_o;
          nxt_rdata[FLAG_CKS_BIT]  = pid_b_cks_error_o;
        end
        default:
          nxt_rdata = '0;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      reg_rdata_o <= '0;
    end
    else
    begin
      reg_rdata_o <= nxt_rdata;
    end
  end

endmodule

// ==== tb/fmt_report_properties.sv ====
// assertions on the ports of the format report block
module fmt_report_properties
  import video_format_pkg::*;
(
  // inputs of the block
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire core_cfg_t   core_cfg_i,
  input wire rx_mode_t    mode_i,
  input wire logic        fractional_i,
  input wire logic [3:0]  lane_lock_i,
  input wire logic [3:0]  lane_prog_i,
  input wire logic [11:0] lane_lines_i,
  input wire logic [11:0] lane_rate_i,
  input wire logic        frame_start_i,
  input wire logic        pid_b_valid_i,
  input wire logic        pid_b_cks_err_i,
  // outputs of the block
  input wire logic [31:0] reg_rdata_o,
  input wire logic [15:0] format_code_o,
  input wire logic        fractional_rate_flag_o,
  input wire logic [10:0] payload_id_line_field_zero_o,
  input wire logic [10:0] payload_id_line_field_one_o,
  input wire logic        pid_b_cks_error_o
);
  logic ext_ff;
  logic watch;
  logic split0;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // mirror of the extraction enable, taken from register writes
  always_ff @(posedge clk_i)
    if (reset_i)
      ext_ff <= 1'b0;
    else if (reg_wr_i && reg_addr_i == ADDR_CTRL)
      ext_ff <= reg_wdata_i[CTRL_EXTRACT_BIT];

  assign watch = ext_ff && (core_cfg_i inside {cfg_3g, cfg_hd_dual,
                                               cfg_triple, cfg_multi});
  assign split0 = lane_lock_i[0] && lane_prog_i[0] &&
                  lane_lines_i[2:0] == lines_1080 &&
                  (mode_i inside {mode_3gb, mode_hd_dual});

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_CKS_FOLLOW: assert property (watch && pid_b_valid_i |=>
    pid_b_cks_error_o == $past(pid_b_cks_err_i))
    else $error("cks flag stale");
  AST_CKS_OFF: assert property (!watch |=> !pid_b_cks_error_o)
    else $error("cks flag unwatched");
  AST_RESET_CODES: assert property (disable iff (1'b0)
    reset_i |=> format_code_o == 16'hffff)
    else $error("code after reset");
  AST_UPPER_LANES: assert property (mode_i != mode_12g |=>
    format_code_o[15:8] == 8'hff)
    else $error("upper lanes coded");
  AST_SINGLE_LANE: assert property (!(mode_i inside
    {mode_6g, mode_12g}) |=> format_code_o[7:4] == 4'hf)
    else $error("lane one coded");
  AST_UNLOCKED: assert property (!lane_lock_i[0] |=>
    format_code_o[3:0] == FMT_UNKNOWN)
    else $error("unlocked code");
  AST_NO_RESERVED: assert property (format_code_o[3:1] != 3'h1 &&
    format_code_o[7:5] != 3'h1 && format_code_o[11:9] != 3'h1 &&
    format_code_o[15:13] != 3'h1)
    else $error("reserved code produced");
  AST_SPLIT_50: assert property (split0 &&
    lane_rate_i[2:0] == rate_50 |=> format_code_o[3:0] == 4'h5)
    else $error("split 50 code");
  AST_SPLIT_60: assert property (split0 &&
    lane_rate_i[2:0] == rate_60 |=> format_code_o[3:0] == 4'h4)
    else $error("split 60 code");
  AST_FRAC: assert property (1'b1 |=>
    fractional_rate_flag_o == $past(fractional_i))
    else $error("frac flag copy");
  AST_LINES_HOLD: assert property (!frame_start_i &&
    !$past(frame_start_i) |=> $stable(payload_id_line_field_zero_o)
    && $stable(payload_id_line_field_one_o))
    else $error("line moved");
  AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("idle read data");
endmodule

bind rx_video_format_report fmt_report_properties chk (.*);

// ==== tb/fmt_sink.sv ====
// downstream model resolving the lane zero code into a frame rate
module fmt_sink
  import video_format_pkg::*;
(
  // report from the block, and the standard indicator
  input  wire logic [3:0]  code_i,
  input  wire logic        frac_i,
  input  wire logic [1:0]  std_i,
  // resolved rate in hundredths of a frame a second, 0 if unresolved
  output logic      [13:0] rate_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // payload identifier would be more exact but is not wired here
  always_comb
  begin
    rate_o = 14'h0;
    if (code_i == FMT_1080I_30 || (code_i == FMT_1080P_30 && std_i[1]))
      rate_o = frac_i ? 14'h176a : 14'h1770;
    else if (code_i == FMT_1080P_30 && std_i == 2'h1)
      rate_o = frac_i ? 14'h0bb5 : 14'h0bb8;
  end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the format report block
module tb
  import video_format_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  core_cfg_t   cfg = cfg_single;
  rx_mode_t    mode = mode_sd;
  logic        frac = 1'b0;
  logic [3:0]  lock = 4'h0;
  logic [3:0]  prog = 4'h0;
  logic [11:0] lines = 12'h0;
  logic [11:0] rate = 12'h0;
  logic        fs = 1'b0;
  logic        found = 1'b0;
  logic        fld = 1'b0;
  logic [10:0] pline = 11'h0;
  logic        bval = 1'b0;
  logic        berr = 1'b0;
  logic [1:0]  std = 2'h0;
  logic [31:0] rdata;
  logic [15:0] code;
  logic [10:0] l0;
  logic [10:0] l1;
  logic [13:0] srate;
  logic        irq;
  logic        fflag;
  logic        cerr;
  logic [31:0] st = 32'h91ad;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cm[4] = '{6, 5, 3, 4};

  rx_video_format_report uut (
    .clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq),
    .core_cfg_i(cfg), .mode_i(mode), .fractional_i(frac),
    .lane_lock_i(lock), .lane_prog_i(prog), .lane_lines_i(lines),
    .lane_rate_i(rate), .frame_start_i(fs), .pid_found_i(found),
    .pid_field_i(fld), .pid_line_i(pline), .pid_b_valid_i(bval),
    .pid_b_cks_err_i(berr), .format_code_o(code),
    .fractional_rate_flag_o(fflag), .payload_id_line_field_zero_o(l0),
    .payload_id_line_field_one_o(l1), .pid_b_cks_error_o(cerr));
  fmt_sink sink (.code_i(code[3:0]), .frac_i(fflag), .std_i(std),
                 .rate_o(srate));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // expected lane code; split transport turns 1080p50/60 interlaced
  function automatic logic [3:0] exp_code(input int m, input int n,
    input logic k, input logic p, input int l, input int r);
    logic q;
    q = p && !((m == 3 || m == 4) && r >= 4);
    if (!k || (m < 5 && n > 0) || (m == 5 && n > 1))
      return 4'hf;
    case (l)
      1: return p ? 4'hf : 4'h0;
      2: return p ? 4'hf : 4'h1;
      3: return (!p || r == 0) ? 4'hf : 4'hc - 4'(r);
      4:
        case (r)
          1: return q ? 4'h6 : 4'he;
          2, 4: return q ? 4'hd : 4'h5;
          3, 5: return q ? 4'hc : 4'h4;
          default: return 4'hf;
        endcase
      default: return 4'hf;
    endcase
  endfunction

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic b_pulse(input int c, input logic e);
    @(posedge clk);
    cfg <= core_cfg_t'(c);
    bval <= 1'b1;
    berr <= e;
    @(posedge clk);
    bval <= 1'b0;
    #1;
  endtask

  // one frame: start pulse, then a find for each field
  task automatic frame(input logic [10:0] a, input logic [10:0] b);
    @(posedge clk);
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
    found <= 1'b1;
    fld <= 1'b0;
    pline <= a;
    @(posedge clk);
    fld <= 1'b1;
    pline <= b;
    @(posedge clk);
    found <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    forever #2 clk = ~clk;
  end

  // safety limit well beyond the few hundred cycles the tests take
  initial
  begin
    #100000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [11:0] ln, rt;
    logic [3:0]  lk, pg;
    logic [13:0] r;
    logic [10:0] a, b;
    logic        f;
    int          m;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("code", {16'h0, code}, 32'hffff);
    chk("lines", {10'h0, l0, l1}, 32'h0);
    rd_reg(ADDR_CTRL, d);
    chk("ctrl", d, 32'h0);
    rd_reg(ADDR_MASK, d);
    chk("mask", d, 32'h0);
    wr_reg(8'h1c, 32'hffffffff);
    rd_reg(8'h1c, d);
    chk("unmapped", d, 32'h0);
    $display("reset and register test done");
    for (int i = 0; i < 64; i++)
    begin
      st = xs(st);
      m = (i < 4) ? cm[i] : int'(st[2:0] % 3'h7);
      lk = (i < 4) ? 4'hf : st[6:3];
      pg = (i < 4) ? 4'hf : st[10:7];
      f = st[11];
      for (int n = 0; n < 4; n++)
      begin
        st = xs(st);
        ln[n*3 +: 3] = (i < 4) ? 3'h4 : 3'(st[7:0] % 8'h5);
        rt[n*3 +: 3] = (i == 2) ? 3'h4 : (i < 4) ? 3'h5 : 3'(st[15:8] % 8'h6);
      end
      @(posedge clk);
      mode <= rx_mode_t'(m);
      lock <= lk;
      prog <= pg;
      lines <= ln;
      rate <= rt;
      frac <= f;
      std <= st[17:16];
      @(posedge clk);
      #1;
      for (int n = 0; n < 4; n++)
        chk("code", {28'h0, code[n*4 +: 4]}, {28'h0, exp_code(m, n, lk[n],
            pg[n], ln[n*3 +: 3], rt[n*3 +: 3])});
      chk("frac", {31'h0, fflag}, {31'h0, f});
      r = 14'h0;
      if (code[3:0] === 4'h4 || (code[3:0] === 4'hc && std[1]))
        r = f ? 14'h176a : 14'h1770;
      else if (code[3:0] === 4'hc && std == 2'h1)
        r = f ? 14'h0bb5 : 14'h0bb8;
      chk("rate", {18'h0, srate}, {18'h0, r});
    end
    $display("format code test done");
    rd_reg(ADDR_STATUS, d);
    chk("status", d, 32'h8);
    wr_reg(ADDR_MASK, 32'h8);
    @(posedge clk);
    #1;
    chk("irq", {31'h0, irq}, 32'h1);
    wr_reg(ADDR_STATUS, 32'h8);
    @(posedge clk);
    #1;
    chk("irq", {31'h0, irq}, 32'h0);
    wr_reg(ADDR_CTRL, 32'h1);
    wr_reg(ADDR_MASK, 32'h1);
    for (int c = 0; c < 6; c++)
    begin
      b_pulse(c, 1'b1);
      chk("cks", {31'h0, cerr}, 32'(c >= 2));
    end
    @(posedge clk);
    #1;
    chk("irq", {31'h0, irq}, 32'h1);
    b_pulse(2, 1'b0);
    chk("cks", {31'h0, cerr}, 32'h0);
    wr_reg(ADDR_CTRL, 32'h0);
    b_pulse(2, 1'b1);
    chk("cks", {31'h0, cerr}, 32'h0);
    wr_reg(ADDR_STATUS, 32'hf);
    @(posedge clk);
    #1;
    chk("irq", {31'h0, irq}, 32'h0);
    $display("checksum and interrupt test done");
    wr_reg(ADDR_CTRL, 32'h1);
    st = xs(st);
    a = st[10:0];
    b = st[21:11];
    for (int i = 0; i < 5; i++)
    begin
      frame(i < 2 ? a : ~a, i < 2 ? b : ~b);
      chk("line0", {21'h0, l0}, {21'h0, i < 2 ? 11'h0 : i < 4 ? a : ~a});
      chk("line1", {21'h0, l1}, {21'h0, i < 2 ? 11'h0 : i < 4 ? b : ~b});
    end
    rd_reg(ADDR_STATUS, d);
    chk("status", d & 32'h6, 32'h6);
    $display("payload line test done");
    give_verdict();
  end
endmodule
